// File: logic/shbc_branch_cond.sv
module shbc_branch_cond (
    // Branch opcode low nibble
    input  wire logic [3:0] opLow,
    // Condition flags
    input  wire logic [7:0] flags,
    // Decision
    output logic            take
);
    import shbc_pkg::*;

    logic evenCond;
    logic nXorV;

    assign nXorV = flags[FLAG_N] ^ flags[FLAG_V];

    always_comb begin
        unique case (opLow[3:1])
            PAIR_ALWAYS: evenCond = 1'b1;
            PAIR_HIGHER: evenCond = ~(flags[FLAG_C] | flags[FLAG_Z]);
            PAIR_CARRY:  evenCond = ~flags[FLAG_C];
            PAIR_EQUAL:  evenCond = ~flags[FLAG_Z];
            PAIR_OVF:    evenCond = ~flags[FLAG_V];
            PAIR_NEG:    evenCond = ~flags[FLAG_N];
            PAIR_GE:     evenCond = ~nXorV;
            PAIR_GT:     evenCond = ~(flags[FLAG_Z] | nXorV);
        endcase
    end

    // Odd opcode of each pair is the complementary test
    assign take = evenCond ^ opLow[0];

endmodule : shbc_branch_cond

// File: logic/shbc_exec.sv
// Summary of operation
// - Shift right, bit 7 kept, bit 0 out
// - Negative is result MSB, zero when 00
// - Overflow is new N xor new C
// - Carry takes operand LSB before shift
// - Opcodes 47,57 accumulators; 77,67 memory
// - Extended/X shifts write back on cycle six
// - Y shift: prefix 18, seven cycles
// - Idle cycles read dummy address FFFF
// - Carry clear branch: PC+2+offset when C=0
// - Branch keeps flags, three cycles, dummy last
// - Signed branch tests 2E,2F,2C,2D
// - Unsigned branch tests 22,23,24,25
// - Bit clear clears bits set in mask
// - Mask at PC+2, PC+3 with prefix
module shbc_exec #(
    parameter logic [15:0] RESET_PC = shbc_pkg::PC_RESET
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Processor bus
    output logic [15:0]      busAddr_r,
    output logic             busRnw_r,
    output logic [7:0]       busWrData_r,
    input  wire logic [7:0]  busRdData,
    // Index registers, held outside
    input  wire logic [15:0] indexX,
    input  wire logic [15:0] indexY,
    // Visible core state
    output logic [7:0]       accA_r,
    output logic [7:0]       accB_r,
    output logic [7:0]       flags_r,
    output logic [15:0]      pc_r,
    output logic             badOpcode_r
);
    import shbc_pkg::*;
    shbc_state_t state_r, stateNxt;
    logic [15:0] busAddrNxt, pcNxt, ea_r, eaNxt, opAddr_r;
    logic        busRnwNxt, yIdx_r, yIdxNxt, badNxt;
    logic [7:0]  busWrDataNxt, op_r, opNxt, opnd_r, opndNxt, mask_r, maskNxt;
    logic [7:0]  accANxt, accBNxt, flagsNxt;
    ////////////////////////////////////////////////////////////////////////
    // Decode
    wire         opFromBus  = (state_r == S_OP) || (state_r == S_PRE);
    wire  [7:0]  opSel      = opFromBus ? busRdData : op_r;
    wire         isShiftA   = (opSel == OP_SHIFT_RIGHT_ARITH_ACC_A);
    wire         isShiftB   = (opSel == OP_SHIFT_RIGHT_ARITH_ACC_B);
    wire         isShiftExt = (opSel == OP_SHIFT_RIGHT_ARITH_EXT);
    wire         isShiftIdx = (opSel == OP_SHIFT_RIGHT_ARITH_IDX);
    wire         isBclrDir  = (opSel == OP_CLEAR_MASKED_BITS_DIR);
    wire         isBclrIdx  = (opSel == OP_CLEAR_MASKED_BITS_IDX);
    wire         isBclr     = isBclrDir || isBclrIdx;
    wire         isBranch   = (opSel[7:4] == OP_JUMP_GROUP);
    wire         isMemOp    = isShiftExt || isShiftIdx || isBclr;
    wire         prefixOk   = isShiftIdx || isBclrIdx;
    wire  [15:0] pcInc      = pc_r + 16'h0001;
    wire  [15:0] idxBase    = yIdx_r ? indexY : indexX;
    wire  [15:0] idxEa      = idxBase + {8'h00, busRdData};
    // Offset is two's complement, so widen with its sign
    wire  [15:0] relExt     = {{8{busRdData[7]}}, busRdData};
    // In the offset cycle pc_r is OP+1, so pcInc is OP+2
    wire  [15:0] brTarget   = pcInc + relExt;
    wire         take;
    shbc_branch_cond u_cond (.opLow(op_r[3:0]), .flags(flags_r), .take(take));
    ////////////////////////////////////////////////////////////////////////
    // Data path
    wire  [7:0]  shiftIn   = isShiftA ? accA_r : (isShiftB ? accB_r : opnd_r);
    wire  [7:0]  shiftRes  = {shiftIn[7], shiftIn[7:1]};
    wire  [7:0]  bclrRes   = opnd_r & ~mask_r;
    wire  [7:0]  result    = isBclr ? bclrRes : shiftRes;
    wire         nNew      = result[7];
    wire         zNew      = (result == 8'h00);
    wire         cNew      = isBclr ? flags_r[FLAG_C] : shiftIn[0];
    wire         vNew      = isBclr ? 1'b0 : (nNew ^ cNew);
    wire  [7:0]  flagsNew  = {flags_r[7:4], nNew, zNew, vNew, cNew};
    ////////////////////////////////////////////////////////////////////////
    // Sequencer; each state is one bus cycle
    always_comb begin
        stateNxt     = state_r;
        busAddrNxt   = DUMMY_ADDR;
        busRnwNxt    = 1'b1;
        busWrDataNxt = 8'h00;
        pcNxt        = pc_r;
        eaNxt        = ea_r;
        opNxt        = op_r;
        yIdxNxt      = yIdx_r;
        opndNxt      = opnd_r;
        maskNxt      = mask_r;
        accANxt      = accA_r;
        accBNxt      = accB_r;
        flagsNxt     = flags_r;
        badNxt       = 1'b0;
        unique case (state_r)
            S_OP: begin
                opNxt      = busRdData;
                yIdxNxt    = 1'b0;
                pcNxt      = pcInc;
                busAddrNxt = pcInc;
                if (busRdData == OP_PREFIX_Y) begin
                    stateNxt = S_PRE;
                end else if (isShiftA || isShiftB) begin
                    stateNxt = S_INH;
                end else if (isBranch || isMemOp) begin
                    stateNxt = S_BYTE1;
                end else begin
                    badNxt   = 1'b1;
                    stateNxt = S_OP;
                end
            end
            S_PRE: begin
                opNxt      = busRdData;
                yIdxNxt    = 1'b1;
                pcNxt      = pcInc;
                busAddrNxt = pcInc;
                stateNxt   = prefixOk ? S_BYTE1 : S_OP;
                badNxt     = ~prefixOk;
            end
            S_INH: begin
                // Dummy read of OP+1; next opcode sits there
                accANxt    = isShiftA ? shiftRes : accA_r;
                accBNxt    = isShiftB ? shiftRes : accB_r;
                flagsNxt   = flagsNew;
                busAddrNxt = pc_r;
                stateNxt   = S_OP;
            end
            S_BYTE1: begin
                pcNxt = pcInc;
                if (isBranch) begin
                    eaNxt    = brTarget;
                    stateNxt = S_BRIDLE;
                end else if (isShiftExt) begin
                    eaNxt      = {busRdData, 8'h00};
                    busAddrNxt = pcInc;
                    stateNxt   = S_BYTE2;
                end else if (isBclrDir) begin
                    eaNxt      = {8'h00, busRdData};
                    busAddrNxt = {8'h00, busRdData};
                    stateNxt   = S_RDOP;
                end else begin
                    eaNxt    = idxEa;
                    stateNxt = S_IDLE1;
                end
            end
            S_BYTE2: begin
                eaNxt      = {ea_r[15:8], busRdData};
                pcNxt      = pcInc;
                busAddrNxt = {ea_r[15:8], busRdData};
                stateNxt   = S_RDOP;
            end
            S_IDLE1: begin
                busAddrNxt = ea_r;
                stateNxt   = S_RDOP;
            end
            S_RDOP: begin
                opndNxt = busRdData;
                if (isBclr) begin
                    // pc_r already points past the address byte
                    busAddrNxt = pc_r;
                    stateNxt   = S_MASK;
                end else begin
                    stateNxt = S_IDLE2;
                end
            end
            S_MASK: begin
                maskNxt  = busRdData;
                pcNxt    = pcInc;
                stateNxt = S_IDLE2;
            end
            S_IDLE2: begin
                busAddrNxt   = ea_r;
                busRnwNxt    = 1'b0;
                busWrDataNxt = result;
                flagsNxt     = flagsNew;
                stateNxt     = S_WR;
            end
            S_WR: begin
                busAddrNxt = pc_r;
                stateNxt   = S_OP;
            end
            S_BRIDLE: begin
                // Flags untouched here
                pcNxt      = take ? ea_r : pc_r;
                busAddrNxt = take ? ea_r : pc_r;
                stateNxt   = S_OP;
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r     <= S_OP;
            busAddr_r   <= RESET_PC;
            busRnw_r    <= 1'b1;
            busWrData_r <= 8'h00;
            pc_r        <= RESET_PC;
            ea_r        <= 16'h0000;
            op_r        <= 8'h00;
            yIdx_r      <= 1'b0;
            opnd_r      <= 8'h00;
            mask_r      <= 8'h00;
            accA_r      <= ACC_RESET;
            accB_r      <= ACC_RESET;
            flags_r     <= FLAGS_RESET;
            badOpcode_r <= 1'b0;
        end else begin
            state_r     <= stateNxt;
            busAddr_r   <= busAddrNxt;
            busRnw_r    <= busRnwNxt;
            busWrData_r <= busWrDataNxt;
            pc_r        <= pcNxt;
            ea_r        <= eaNxt;
            op_r        <= opNxt;
            yIdx_r      <= yIdxNxt;
            opnd_r      <= opndNxt;
            mask_r      <= maskNxt;
            accA_r      <= accANxt;
            accB_r      <= accBNxt;
            flags_r     <= flagsNxt;
            badOpcode_r <= badNxt;
        end
    end
    // Address of the first opcode byte, for checking only
    always_ff @(posedge clk) begin
        if (rst) begin
            opAddr_r <= 16'h0000;
        end else if (state_r == S_OP) begin
            opAddr_r <= busAddr_r;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_dummy_cycle:
    assert property (@(posedge clk) disable iff (rst)
        (state_r == S_IDLE1 || state_r == S_IDLE2 || state_r == S_BRIDLE)
            |-> (busAddr_r == DUMMY_ADDR && busRnw_r))
        else $error("idle cycle not a dummy read of ffff");
    a_write_only:
    assert property (@(posedge clk) disable iff (rst)
        !busRnw_r |-> (state_r == S_WR && busAddr_r == ea_r && $past(busRnw_r)))
        else $error("write outside the write-back cycle");
    a_ext_six:
    assert property (@(posedge clk) disable iff (rst)
        (state_r == S_OP && busRdData == OP_SHIFT_RIGHT_ARITH_EXT)
            |-> busRnw_r [*5] ##1 !busRnw_r ##1 busRnw_r)
        else $error("extended shift write not on cycle six");
    a_yidx_seven:
    assert property (@(posedge clk) disable iff (rst)
        (state_r == S_OP && busRdData == OP_PREFIX_Y)
            ##1 (busRdData == OP_SHIFT_RIGHT_ARITH_IDX)
            |-> ##5 (!busRnw_r && busAddr_r == indexY + {8'h00, $past(busRdData, 4)}))
        else $error("Y shift write not on cycle seven at Y plus offset");
    a_shift_carry:
    assert property (@(posedge clk) disable iff (rst)
        (state_r == S_WR && !isBclr)
            |-> (busWrData_r == {opnd_r[7], opnd_r[7:1]} && flags_r[FLAG_C] == opnd_r[0]))
        else $error("shift result or carry wrong");
    a_shift_nz:
    assert property (@(posedge clk) disable iff (rst)
        (state_r == S_WR && !isBclr)
            |-> (flags_r[FLAG_N] == busWrData_r[7]
                 && flags_r[FLAG_Z] == (busWrData_r == 8'h00)))
        else $error("shift N or Z wrong");
    // V judged from the operand itself, not from the new N and C
    a_shift_v:
    assert property (@(posedge clk) disable iff (rst)
        (state_r == S_OP && $past(state_r) == S_INH)
            |-> (flags_r[FLAG_V] == ($past(shiftIn[7]) ^ $past(shiftIn[0]))))
        else $error("accumulator shift V wrong");
    a_clear_masked_bits_data:
    assert property (@(posedge clk) disable iff (rst)
        (state_r == S_WR && isBclr) |-> (busWrData_r == (opnd_r & ~mask_r)))
        else $error("bit clear result wrong");
    a_mask_addr:
    assert property (@(posedge clk) disable iff (rst)
        state_r == S_MASK
            |-> (busAddr_r == opAddr_r + (yIdx_r ? 16'h0003 : 16'h0002)))
        else $error("mask byte fetched from wrong address");
    a_branch_flags:
    assert property (@(posedge clk) disable iff (rst)
        (state_r == S_BYTE1 && isBranch) |=> (state_r == S_BRIDLE) ##1
            (state_r == S_OP && $stable(flags_r)))
        else $error("branch changed flags or cycle count");
    a_carry_branch:
    assert property (@(posedge clk) disable iff (rst)
        (state_r == S_BYTE1 && op_r == OP_JUMP_IF_CARRY_ZERO)
            |-> ##2 (pc_r == (flags_r[FLAG_C] ? $past(pcInc, 2)
                                              : $past(pcInc, 2) + $past(relExt, 2))))
        else $error("carry clear branch target wrong");
    a_signed_gt:
    assert property (@(posedge clk) disable iff (rst)
        (state_r == S_BRIDLE && op_r == OP_JUMP_IF_GREATER_SIGNED)
            |-> (take == !(flags_r[FLAG_Z] | (flags_r[FLAG_N] ^ flags_r[FLAG_V]))))
        else $error("signed greater decision wrong");

endmodule : shbc_exec

// File: logic/shbc_pkg.sv
package shbc_pkg;

    // Opcodes
    localparam logic [7:0] OP_PREFIX_Y               = 8'h18;
    localparam logic [7:0] OP_SHIFT_RIGHT_ARITH_ACC_A = 8'h47;
    localparam logic [7:0] OP_SHIFT_RIGHT_ARITH_ACC_B = 8'h57;
    localparam logic [7:0] OP_SHIFT_RIGHT_ARITH_EXT  = 8'h77;
    localparam logic [7:0] OP_SHIFT_RIGHT_ARITH_IDX  = 8'h67;
    localparam logic [7:0] OP_CLEAR_MASKED_BITS_DIR  = 8'h15;
    localparam logic [7:0] OP_CLEAR_MASKED_BITS_IDX  = 8'h1d;
    localparam logic [7:0] OP_JUMP_IF_CARRY_ZERO     = 8'h24;
    localparam logic [7:0] OP_JUMP_IF_GREATER_SIGNED = 8'h2e;
    localparam logic [3:0] OP_JUMP_GROUP             = 4'h2;

    // Branch pairs, opcode bits 3:1; odd opcode takes the complement
    localparam logic [2:0] PAIR_ALWAYS  = 3'h0;
    localparam logic [2:0] PAIR_HIGHER  = 3'h1;
    localparam logic [2:0] PAIR_CARRY   = 3'h2;
    localparam logic [2:0] PAIR_EQUAL   = 3'h3;
    localparam logic [2:0] PAIR_OVF     = 3'h4;
    localparam logic [2:0] PAIR_NEG     = 3'h5;
    localparam logic [2:0] PAIR_GE      = 3'h6;
    localparam logic [2:0] PAIR_GT      = 3'h7;

    // Condition flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;

    // Bus and reset values
    localparam logic [15:0] DUMMY_ADDR  = 16'hffff;
    localparam logic [15:0] PC_RESET    = 16'h0000;
    localparam logic [7:0]  ACC_RESET   = 8'h00;
    localparam logic [7:0]  FLAGS_RESET = 8'h00;

    typedef enum logic [3:0] {
        S_OP, S_PRE, S_INH, S_BYTE1, S_BYTE2, S_IDLE1,
        S_RDOP, S_MASK, S_IDLE2, S_WR, S_BRIDLE
    } shbc_state_t;

endpackage : shbc_pkg

// File: verification/shbc_mem_model.sv
module shbc_mem_model (
    // Clock
    input  wire logic        clk,
    // Processor bus
    input  wire logic [15:0] busAddr,
    input  wire logic        busRnw,
    input  wire logic [7:0]  busWrData,
    output logic [7:0]       busRdData
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [0:65535];
    logic [7:0] noise_r;

    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'h00;
        end
        noise_r = 8'h5a;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Zero-wait answer; dummy address gets a changing pattern so nothing leans on it
    assign busRdData = (busAddr == 16'hffff) ? noise_r : mem[busAddr];

    always @(posedge clk) begin
        noise_r <= ~noise_r + 8'h01;
        if (busRnw == 1'b0) begin
            mem[busAddr] <= busWrData;
        end
    end
endmodule : shbc_mem_model

// File: verification/tb_shbc_exec.sv
module tb_shbc_exec;
    timeunit 1ns;
    timeprecision 1ps;
    import shbc_pkg::*;

    logic        clk;
    logic        rst;
    logic [15:0] indexX;
    logic [15:0] indexY;
    logic [15:0] busAddr;
    logic        busRnw;
    logic [7:0]  busWrData;
    logic [7:0]  busRdData;
    logic [7:0]  accA;
    logic [7:0]  accB;
    logic [7:0]  flags;
    logic [15:0] pc;
    logic        badOpcode;
    int          error_cnt = 0;
    int          cmp_count = 0;
    logic [15:0] walkQ [$];

    shbc_exec i_dut (
        .clk(clk), .rst(rst), .busAddr_r(busAddr), .busRnw_r(busRnw),
        .busWrData_r(busWrData), .busRdData(busRdData), .indexX(indexX),
        .indexY(indexY), .accA_r(accA), .accB_r(accB), .flags_r(flags),
        .pc_r(pc), .badOpcode_r(badOpcode)
    );

    shbc_mem_model i_mem (
        .clk(clk), .busAddr(busAddr), .busRnw(busRnw),
        .busWrData(busWrData), .busRdData(busRdData)
    );

    initial begin
        clk = 1'b0;
    end
    always #12.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    // Leaves at a falling edge with the first opcode cycle showing
    task automatic do_reset(input int n);
        @(negedge clk);
        rst = 1'b1;
        repeat (n) @(negedge clk);
        rst = 1'b0;
    endtask : do_reset

    task automatic load(input logic [7:0] p[$]);
        foreach (p[i]) begin
            i_mem.mem[16'(i)] = p[i];
        end
    endtask : load

    // One entry of walkQ per bus cycle; only entry wrIdx is a write
    task automatic walk(input int wrIdx, input logic [7:0] wd);
        foreach (walkQ[i]) begin
            check(busAddr, walkQ[i]);
            check({15'h0, busRnw}, {15'h0, (i != wrIdx)});
            check({15'h0, badOpcode}, 16'h0000);
            if (i == wrIdx) check({8'h0, busWrData}, {8'h0, wd});
            @(negedge clk);
        end
    endtask : walk

    // Result and {N,Z,V,C} of an arithmetic right shift
    function automatic logic [11:0] shift_right_arith_mem(input logic [7:0] v);
        logic [7:0] r;
        r = {v[7], v[7:1]};
        return {r, r[7], r == 8'h00, r[7] ^ v[0], v[0]};
    endfunction : shift_right_arith_mem

    function automatic logic taken(input logic [7:0] op, input logic [3:0] f);
        logic n, z, v, c, t;
        {n, z, v, c} = f;
        case (op[3:1])
            3'h0: t = 1'b1;
            3'h1: t = ~(c | z);
            3'h2: t = ~c;
            3'h3: t = ~z;
            3'h4: t = ~v;
            3'h5: t = ~n;
            3'h6: t = ~(n ^ v);
            default: t = ~(z | (n ^ v));
        endcase
        return op[0] ? ~t : t;
    endfunction : taken

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_acc_shift;
        do_reset(2);
        load('{8'h77, 8'h00, 8'h40, 8'h47, 8'h57});
        i_mem.mem[16'h0040] = 8'h81;
        walkQ = '{16'h0, 16'h1, 16'h2, 16'h40, 16'hffff, 16'h40, 16'h3, 16'h4,
                  16'h4, 16'h5, 16'h5};
        walk(5, 8'hc0);
        check({8'h0, accA}, 16'h0000);
        check({8'h0, accB}, 16'h0000);
        // Old carry was set; shifting 00 must clear it
        check({8'h0, flags}, 16'h0004);
        // Byte 00 at OP+1 of the second shift is no opcode of this block
        check({15'h0, badOpcode}, 16'h0001);
        check(pc, 16'h0006);
    endtask : t_acc_shift

    // Byte after the prefix that no Y form takes is dropped; fetch resumes at OP+2
    task automatic t_bad_prefix;
        do_reset(2);
        load('{8'h18, 8'h47});
        walkQ = '{16'h0, 16'h1};
        walk(-1, 8'h00);
        check(busAddr, 16'h0002);
        check(pc, 16'h0002);
        check({15'h0, badOpcode}, 16'h0001);
    endtask : t_bad_prefix

    task automatic t_mem_shift(input int mode, input logic [7:0] v);
        logic [15:0] ea;
        logic [11:0] e;
        int          w;
        e = shift_right_arith_mem(v);
        do_reset(2);
        if (mode == 0) begin
            load('{8'h77, 8'h12, 8'h34});
            ea = 16'h1234;
            walkQ = '{16'h0, 16'h1, 16'h2, ea, 16'hffff, ea, 16'h3};
            w = 5;
        end else if (mode == 1) begin
            load('{8'h67, 8'hff});
            ea = 16'h20ff;
            walkQ = '{16'h0, 16'h1, 16'hffff, ea, 16'hffff, ea, 16'h2};
            w = 5;
        end else begin
            load('{8'h18, 8'h67, 8'h80});
            ea = 16'h4070;
            walkQ = '{16'h0, 16'h1, 16'h2, 16'hffff, ea, 16'hffff, ea, 16'h3};
            w = 6;
        end
        i_mem.mem[ea] = v;
        walk(w, e[11:4]);
        check({8'h0, i_mem.mem[ea]}, {8'h0, e[11:4]});
        check({8'h0, flags}, {12'h0, e[3:0]});
    endtask : t_mem_shift

    task automatic t_bit_clear(input int mode);
        logic [7:0]  v;
        logic [7:0]  m;
        logic [15:0] ea;
        int          w;
        do_reset(2);
        if (mode == 0) begin
            {v, m, ea} = {8'ha5, 8'h0f, 16'h0050};
            load('{8'h15, 8'h50, m});
            walkQ = '{16'h0, 16'h1, ea, 16'h2, 16'hffff, ea, 16'h3};
            w = 5;
        end else if (mode == 1) begin
            {v, m, ea} = {8'hff, 8'h3c, 16'h20ff};
            load('{8'h1d, 8'hff, m});
            walkQ = '{16'h0, 16'h1, 16'hffff, ea, 16'h2, 16'hffff, ea, 16'h3};
            w = 6;
        end else begin
            {v, m, ea} = {8'h81, 8'h81, 16'h4070};
            load('{8'h18, 8'h1d, 8'h80, m});
            walkQ = '{16'h0, 16'h1, 16'h2, 16'hffff, ea, 16'h3, 16'hffff, ea, 16'h4};
            w = 7;
        end
        i_mem.mem[ea] = v;
        walk(w, v & ~m);
        check({8'h0, flags}, {12'h0, v[7] & ~m[7], (v & ~m) == 8'h00, 2'b00});
    endtask : t_bit_clear

    // Shift sets the flags, then the branch; offset sign alternates with opcode
    task automatic t_branch(input logic [7:0] op, input logic [7:0] v);
        logic [11:0] e;
        logic [7:0]  rr;
        logic [15:0] tgt;
        e = shift_right_arith_mem(v);
        rr = op[0] ? 8'h10 : 8'hf0;
        tgt = taken(op, e[3:0]) ? 16'h0005 + {{8{rr[7]}}, rr} : 16'h0005;
        do_reset(2);
        load('{8'h77, 8'h00, 8'h40, op, rr});
        i_mem.mem[16'h0040] = v;
        walkQ = '{16'h0, 16'h1, 16'h2, 16'h40, 16'hffff, 16'h40, 16'h3, 16'h4,
                  16'hffff, tgt};
        walk(5, e[11:4]);
        check({8'h0, flags}, {12'h0, e[3:0]});
        // One opcode fetch at the target has passed since the branch
        check(pc, tgt + 16'h0001);
    endtask : t_branch

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        indexX = 16'h2000;
        indexY = 16'h3ff0;
        repeat (12) @(negedge clk);
        t_acc_shift();
        t_bad_prefix();
        for (int md = 0; md < 3; md++) begin
            t_mem_shift(md, 8'h81);
            t_mem_shift(md, 8'h80);
            t_mem_shift(md, 8'h01);
            t_mem_shift(md, 8'h7e);
            t_bit_clear(md);
        end
        // Operands give flag sets 0, ZVC, NC and NV
        for (int op = 8'h20; op <= 8'h2f; op++) begin
            t_branch(8'(op), 8'h02);
            t_branch(8'(op), 8'h01);
            t_branch(8'(op), 8'h81);
            t_branch(8'(op), 8'h80);
        end
        give_verdict();
    end

    // Cuts a hang short
    initial begin
        repeat (50000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
endmodule : tb_shbc_exec
